// *** hw/adcc_pkg.sv ***
// Package: constants and types of the converter control block
package adcc_pkg;
  localparam int          CLKSEL_W      = 3;
  localparam int          CHAN_W        = 4;
  localparam int          RES_W         = 8;
  localparam int          PERIODS_TOTAL = 10;
  localparam logic [2:0]  CLK_DIV2      = 3'h0;
  localparam logic [2:0]  CLK_DIV4      = 3'h4;
  localparam logic [2:0]  CLK_DIV8      = 3'h1;
  localparam logic [2:0]  CLK_DIV16     = 3'h5;
  localparam logic [2:0]  CLK_DIV32     = 3'h2;
  localparam logic [2:0]  CLK_DIV64     = 3'h6;
  localparam logic [1:0]  CLK_RC_LOW    = 2'h3;
  localparam logic [1:0]  REF_SUPPLY    = 2'h0;
  localparam logic [1:0]  REF_EXTERNAL  = 2'h1;
  localparam logic [1:0]  REF_FIXED     = 2'h2;
  localparam logic [3:0]  CHAN_RSV_LO   = 4'h5;
  localparam logic [3:0]  CHAN_RSV_HI   = 4'h7;
  localparam logic [3:0]  CHAN_RSV_E    = 4'hE;
  localparam logic [3:0]  CHAN_FIXED    = 4'hF;
  localparam logic [7:0]  RESULT_RST    = 8'h00;
  localparam logic [5:0]  DIV_RST       = 6'h00;
  localparam logic [3:0]  PERIOD_LAST   = 4'h9;
  localparam logic [7:0]  MSB_ONE       = 8'h80;
  localparam int          INSTR_NS      = 200;
  localparam int          CLK_NS        = 8;
  localparam int          INSTR_CYC     = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0]  INSTR_LAST    = 5'(INSTR_CYC - 1);
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_WAIT = 2'b01,
    ADCC_CONV = 2'b11
  } adcc_state_e;
endpackage

// *** hw/adcc_tick_div.sv ***
// Conversion clock enable: system divider or resynchronised RC clock
`timescale 1ns/1ps
module adcc_tick_div (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          run,
  input  wire logic [adcc_pkg::CLKSEL_W-1:0] clkSel,
  input  wire logic                          rcClk,
  output logic                               tick
);
  import adcc_pkg::*;
  typedef struct packed {
    logic [5:0] cnt;
    logic [2:0] rcSync;
    logic       tick;
  } adcc_div_s;
  adcc_div_s s_q, s_d;
  logic [5:0] lastCnt;
  always_comb begin
    case (clkSel)
      CLK_DIV2:  lastCnt = 6'h01;
      CLK_DIV4:  lastCnt = 6'h03;
      CLK_DIV8:  lastCnt = 6'h07;
      CLK_DIV16: lastCnt = 6'h0F;
      CLK_DIV32: lastCnt = 6'h1F;
      CLK_DIV64: lastCnt = 6'h3F;
      default:   lastCnt = 6'h00;
    endcase
  end
  always_comb begin
    s_d        = s_q;
    s_d.rcSync = {s_q.rcSync[1:0], rcClk};
    s_d.tick   = 1'b0;
    if (!run) begin
      s_d.cnt = DIV_RST;
    end else if (clkSel[1:0] == CLK_RC_LOW) begin
      // Rising edge seen only after both sync stages
      s_d.tick = s_q.rcSync[1] & ~s_q.rcSync[2];
    end else if (s_q.cnt >= lastCnt) begin
      s_d.cnt  = DIV_RST;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 6'h01;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule

// *** hw/adcc_conv_ctrl.sv ***
// Top: successive-approximation converter sequencing and control
`timescale 1ns/1ps
module adcc_conv_ctrl (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          converterOn,
  input  wire logic                          goSetWr,
  input  wire logic                          goClearWr,
  input  wire logic                          specialTrig,
  input  wire logic [adcc_pkg::CLKSEL_W-1:0] convClockSelect,
  input  wire logic [1:0]                    posRefSelect,
  input  wire logic [adcc_pkg::CHAN_W-1:0]   inputChannelSelect,
  input  wire logic                          convIrqEnable,
  input  wire logic                          doneFlagClear,
  input  wire logic                          sleepMode,
  input  wire logic                          rcClk,
  input  wire logic                          compAbove,
  output logic                               goDone,
  output logic                               convDoneFlag,
  output logic                               convIrq,
  output logic                               wakeReq,
  output logic [adcc_pkg::RES_W-1:0]         convResultReg,
  output logic [adcc_pkg::RES_W-1:0]         dacCode,
  output logic                               analogPower,
  output logic [1:0]                         posRefRoute,
  output logic [adcc_pkg::CHAN_W-1:0]        chanRoute,
  output logic                               chanValid,
  output logic                               counterClear
);
  import adcc_pkg::*;
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    adcc_state_e state;
    logic        go;
    logic        flag;
    logic        irq;
    logic        wake;
    logic        power;
    logic        sleptOff;
    logic [3:0]  perCnt;
    logic [4:0]  instrCnt;
    logic [7:0]  sar;
    logic [7:0]  trial;
    logic [7:0]  dac;
    logic        lastBit;
    logic [7:0]  result;
    logic [1:0]  refSel;
    logic [3:0]  chan;
    logic        chanOk;
    logic        ctrClr;
    logic [1:0]  cmpSync;
  } adcc_top_s;
  adcc_top_s s_q, s_d;
  logic tick;
  logic useRc;
  logic [7:0] partial;
  assign useRc = (convClockSelect[1:0] == CLK_RC_LOW);
  adcc_tick_div u_div (
    .clk    (clk),
    .rstn   (rstn),
    .run    (s_q.state != ADCC_IDLE),
    .clkSel (convClockSelect),
    .rcClk  (rcClk),
    .tick   (tick)
  );
  // Unresolved bits copy the last resolved bit
  always_comb begin
    partial = s_q.sar;
    for (int i = 0; i < RES_W; i++) begin
      // Trial bit and all bits below it are still open
      if ((8'h01 << i) <= s_q.trial) begin
        partial[i] = s_q.lastBit;
      end
    end
  end
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.cmpSync = {s_q.cmpSync[0], compAbove};
    s_d.ctrClr  = specialTrig;
    s_d.refSel  = posRefSelect;
    s_d.chan    = inputChannelSelect;
    s_d.chanOk  = !((inputChannelSelect >= CHAN_RSV_LO && inputChannelSelect <= CHAN_RSV_HI)
                    || inputChannelSelect == CHAN_RSV_E);
    if (!converterOn) begin
      s_d.sleptOff = 1'b0;
    end
    if (!sleepMode) begin
      s_d.sleptOff = 1'b0;
    end
    s_d.power = converterOn && !s_d.sleptOff;
    if (doneFlagClear) begin
      s_d.flag = 1'b0;
    end
    case (s_q.state)
      ADCC_IDLE: begin
        if ((goSetWr || specialTrig) && converterOn) begin
          s_d.go       = 1'b1;
          s_d.sleptOff = 1'b0;
          s_d.power    = 1'b1;
          s_d.instrCnt = 5'h00;
          s_d.state    = useRc ? ADCC_WAIT : ADCC_CONV;
          s_d.sar      = RESULT_RST;
          s_d.trial    = MSB_ONE;
          s_d.perCnt   = 4'h0;
          // Stale bit of an earlier conversion must not fill an early abort
          s_d.lastBit  = 1'b0;
        end
      end
      ADCC_WAIT: begin
        if (s_q.instrCnt == INSTR_LAST) begin
          s_d.state = ADCC_CONV;
        end else begin
          s_d.instrCnt = s_q.instrCnt + 5'h01;
        end
      end
      ADCC_CONV: begin
        if (tick) begin
          s_d.perCnt = s_q.perCnt + 4'h1;
          if (s_q.perCnt >= 4'h1 && s_q.trial != 8'h00) begin
            // MSB first, one bit per period
            if (!s_q.cmpSync[1]) begin
              s_d.sar = s_q.sar | s_q.trial;
            end
            s_d.lastBit = !s_q.cmpSync[1];
            s_d.trial   = s_q.trial >> 1;
          end
        end
        if (tick && s_q.perCnt == PERIOD_LAST) begin
          s_d.go     = 1'b0;
          s_d.flag   = 1'b1;
          s_d.result = s_q.sar;
          s_d.state  = ADCC_IDLE;
          if (sleepMode && !convIrqEnable) begin
            s_d.sleptOff = 1'b1;
            s_d.power    = 1'b0;
          end
        end
      end
      default: begin
        s_d.state = ADCC_IDLE;
      end
    endcase
    if (s_q.state != ADCC_IDLE && (goClearWr || !converterOn)) begin
      s_d.go     = 1'b0;
      s_d.result = partial;
      s_d.state  = ADCC_IDLE;
    end
    if (s_q.state != ADCC_IDLE && sleepMode && !useRc) begin
      s_d.go       = 1'b0;
      s_d.state    = ADCC_IDLE;
      s_d.sleptOff = 1'b1;
      s_d.power    = 1'b0;
    end
    s_d.dac  = s_d.sar | s_d.trial;
    s_d.irq  = s_d.flag && convIrqEnable;
    s_d.wake = s_d.irq && sleepMode;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign goDone        = s_q.go;
  assign convDoneFlag  = s_q.flag;
  assign convIrq       = s_q.irq;
  assign wakeReq       = s_q.wake;
  assign convResultReg = s_q.result;
  assign dacCode       = s_q.dac;
  assign analogPower   = s_q.power;
  assign posRefRoute   = s_q.refSel;
  assign chanRoute     = s_q.chan;
  assign chanValid     = s_q.chanOk;
  assign counterClear  = s_q.ctrClr;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence finishSeq;
    s_q.state == ADCC_CONV && tick && s_q.perCnt == PERIOD_LAST && !goClearWr && converterOn
      && !(sleepMode && !useRc);
  endsequence
  doneSets_a: assert property (@(posedge clk) disable iff (!rstn)
    finishSeq |=> convDoneFlag && !goDone) else $error("done not set at end");
  resultLoad_a: assert property (@(posedge clk) disable iff (!rstn)
    finishSeq |=> convResultReg == $past(s_q.sar)) else $error("result not loaded");
  noHwClear_a: assert property (@(posedge clk) disable iff (!rstn)
    convDoneFlag && !doneFlagClear |=> convDoneFlag) else $error("flag cleared by hw");
  irqGate_a: assert property (@(posedge clk) disable iff (!rstn)
    convIrq |-> $past(s_d.flag) && $past(convIrqEnable)) else $error("irq without cause");
  powerOff_a: assert property (@(posedge clk) disable iff (!rstn)
    !converterOn |=> !analogPower) else $error("powered while off");
  rcWait_a: assert property (@(posedge clk) disable iff (!rstn)
    s_q.state == ADCC_IDLE && goSetWr && converterOn && useRc |=> s_q.state == ADCC_WAIT)
    else $error("no rc wait");
  sleepAbort_a: assert property (@(posedge clk) disable iff (!rstn)
    s_q.state == ADCC_CONV && sleepMode && !useRc |=> !goDone && !analogPower)
    else $error("sleep did not abort");
  trigClear_a: assert property (@(posedge clk) disable iff (!rstn)
    specialTrig |=> counterClear) else $error("counter not cleared");
  tenPeriods_a: assert property (@(posedge clk) disable iff (!rstn)
    s_q.state == ADCC_CONV |-> s_q.perCnt <= PERIOD_LAST) else $error("too many periods");
endmodule

// *** tb/adcc_tb.sv ***
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module tb;
  import adcc_pkg::*;
  typedef struct {
    logic [2:0] sel;
    int         n;
    logic [7:0] tgt;
    logic [1:0] pref;
    logic [3:0] ch;
    logic       ie;
  } adcc_row_s;
  logic       clk, rstn, converterOn, goSetWr, goClearWr, specialTrig, convIrqEnable, doneFlagClear;
  logic       sleepMode, rcClk, compAbove, goDone, convDoneFlag, convIrq, wakeReq, analogPower;
  logic       chanValid, counterClear;
  logic [2:0] convClockSelect;
  logic [1:0] posRefSelect, posRefRoute;
  logic [3:0] inputChannelSelect, chanRoute, rcCnt;
  logic [7:0] convResultReg, dacCode, tgt, keep;
  int         n_fail, checks_done, cyc, c, lo, hi;
  adcc_row_s  rows [8];
  adcc_conv_ctrl dut (.clk(clk), .rstn(rstn), .converterOn(converterOn), .goSetWr(goSetWr),
    .goClearWr(goClearWr), .specialTrig(specialTrig), .convClockSelect(convClockSelect),
    .posRefSelect(posRefSelect), .inputChannelSelect(inputChannelSelect), .convIrqEnable(convIrqEnable),
    .doneFlagClear(doneFlagClear), .sleepMode(sleepMode), .rcClk(rcClk), .compAbove(compAbove),
    .goDone(goDone), .convDoneFlag(convDoneFlag), .convIrq(convIrq), .wakeReq(wakeReq),
    .convResultReg(convResultReg), .dacCode(dacCode), .analogPower(analogPower), .posRefRoute(posRefRoute),
    .chanRoute(chanRoute), .chanValid(chanValid), .counterClear(counterClear));
  // ----------------------------------------
  // Clock, RC source, comparator, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Comparator lags a few cycles; fine for divisors of 4 and up
  always @(posedge clk) begin
    rcCnt <= rcCnt + 4'h1;
    rcClk <= rcCnt[3];
    compAbove <= (dacCode > tgt);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic start();
    @(posedge clk) goSetWr <= 1'b1;
    @(posedge clk) goSetWr <= 1'b0;
  endtask
  task automatic clear_flag();
    @(posedge clk) doneFlagClear <= 1'b1;
    @(posedge clk) doneFlagClear <= 1'b0;
  endtask
  task automatic wait_done(input int n, input logic [2:0] sel);
    c = 0;
    // Sampled mid-cycle, never in the edge that launches it
    do begin
      @(negedge clk);
      c++;
    end while (goDone !== 1'b0 && c < 2000);
    lo = 9 * n + ((sel[1:0] == 2'h3) ? INSTR_CYC : 0);
    hi = lo + 2 * n + 6;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rstn, converterOn, goSetWr, goClearWr, specialTrig, convIrqEnable, doneFlagClear, sleepMode} = '0;
    {rcClk, compAbove, convClockSelect, posRefSelect, inputChannelSelect, rcCnt, tgt} = '0;
    {n_fail, checks_done, cyc} = '0;
    rows = '{'{3'h0, 2, 8'hFF, 2'h0, 4'h0, 1'b0}, '{3'h4, 4, 8'h00, 2'h1, 4'h5, 1'b1},
             '{3'h1, 8, 8'hA5, 2'h2, 4'h7, 1'b0}, '{3'h5, 16, 8'h3C, 2'h0, 4'h8, 1'b1},
             '{3'h2, 32, 8'h69, 2'h1, 4'hE, 1'b0}, '{3'h6, 64, 8'hC3, 2'h2, 4'hF, 1'b0},
             '{3'h3, 16, 8'h5A, 2'h0, 4'hD, 1'b1}, '{3'h7, 16, 8'h96, 2'h1, 4'h1, 1'b0}};
    repeat (8) @(negedge clk);
    check({goDone, convDoneFlag, analogPower, convResultReg}, 32'h0);
    @(posedge clk) rstn <= 1'b1;
    @(posedge clk) converterOn <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk);
      convClockSelect <= rows[i].sel;
      posRefSelect <= rows[i].pref;
      inputChannelSelect <= rows[i].ch;
      convIrqEnable <= rows[i].ie;
      tgt <= rows[i].tgt;
      repeat (4) @(negedge clk);
      check(posRefRoute, rows[i].pref);
      check({chanValid, chanRoute}, {!(rows[i].ch inside {[4'h5:4'h7], 4'hE}), rows[i].ch});
      start();
      @(negedge clk);
      check({goDone, analogPower, dacCode}, {2'h3, 8'h80});
      wait_done(rows[i].n, rows[i].sel);
      check(c >= lo && c <= hi, 1'b1);
      check({convResultReg, convDoneFlag}, {rows[i].tgt, 1'b1});
      repeat (6) @(negedge clk);
      check({convDoneFlag, convIrq}, {1'b1, rows[i].ie});
      clear_flag();
      @(negedge clk);
      check(convDoneFlag, 1'b0);
      $display("row %0d finished", i);
    end
    // Start refused while converter off
    @(posedge clk) converterOn <= 1'b0;
    start();
    repeat (3) @(negedge clk);
    check({goDone, analogPower}, 2'h0);
    @(posedge clk) converterOn <= 1'b1;
    // Abort between ticks four and five: three bits resolved
    {convClockSelect, convIrqEnable, tgt} <= {3'h6, 1'b0, 8'hA5};
    start();
    repeat (288) @(posedge clk);
    goClearWr <= 1'b1;
    @(posedge clk) goClearWr <= 1'b0;
    @(negedge clk);
    check({goDone, convResultReg}, {1'b0, tgt[7:5], {5{tgt[5]}}});
    $display("abort test finished");
    // Hardware start from the special event trigger
    @(posedge clk) specialTrig <= 1'b1;
    @(posedge clk) specialTrig <= 1'b0;
    @(negedge clk);
    check({goDone, counterClear}, 2'h3);
    @(negedge clk);
    check(counterClear, 1'b0);
    wait_done(64, 3'h6);
    check({convDoneFlag, convResultReg}, {1'b1, tgt});
    clear_flag();
    // Sleep with a system-derived clock aborts and powers down
    keep = convResultReg;
    start();
    repeat (100) @(posedge clk);
    sleepMode <= 1'b1;
    repeat (4) @(negedge clk);
    check({goDone, analogPower, convResultReg}, {2'h0, keep});
    @(posedge clk) sleepMode <= 1'b0;
    $display("trigger and sleep tests finished");
    // RC clock in sleep: completes, then powers down or wakes
    for (int ie = 0; ie < 2; ie++) begin
      @(posedge clk);
      {convClockSelect, convIrqEnable} <= {3'h3, ie[0]};
      start();
      sleepMode <= 1'b1;
      wait_done(16, 3'h3);
      check(c >= lo && c <= hi, 1'b1);
      repeat (3) @(negedge clk);
      check({convDoneFlag, wakeReq}, {1'b1, ie[0]});
      check(analogPower, ie[0]);
      @(posedge clk) sleepMode <= 1'b0;
      clear_flag();
    end
    // Reset in mid-conversion
    start();
    repeat (30) @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    check({goDone, analogPower, convDoneFlag, convIrq, convResultReg}, 12'h000);
    @(posedge clk) rstn <= 1'b1;
    $display("sleep and reset tests finished");
    give_verdict();
  end
endmodule
